// File: shared/smfr_defines.svh
// register offsets, bit positions and timing figures of the fault reaction
`ifndef SMFR_DEFINES_SVH
`define SMFR_DEFINES_SVH
`define SMFR_ADDR_W 4
`define SMFR_DATA_W 8
`define SMFR_NFAULT 13
`define SMFR_A_UV_STAT 4'h0
`define SMFR_A_OV_STAT 4'h1
`define SMFR_A_PROT_STAT 4'h2
`define SMFR_A_EXT_STAT 4'h3
`define SMFR_A_CFG 4'h4
`define SMFR_A_CTRL 4'h5
`define SMFR_A_STATE 4'h6
`define SMFR_A_IRQ_STAT 4'h7
`define SMFR_A_IRQ_EN 4'h8
`define SMFR_A_IRQ_CLR 4'h9
`define SMFR_UV_BOOST_BIT 3
`define SMFR_UV_INTERNAL_REGULATOR_RAIL_BIT 4
`define SMFR_UV_VBAT_BIT 6
`define SMFR_OV_BOOST_BIT 3
`define SMFR_OV_INTERNAL_REGULATOR_RAIL_BIT 4
`define SMFR_OV_IO_BIT 7
`define SMFR_PROT_HOV_BIT 3
`define SMFR_EXT_UV_LSB 0
`define SMFR_EXT_OV_LSB 4
`define SMFR_CTRL_RECOVER_BIT 0
`define SMFR_IRQ_UV_BIT 0
`define SMFR_IRQ_OV_BIT 1
`define SMFR_IRQ_PROT_BIT 2
`define SMFR_IRQ_EXT_BIT 3
`define SMFR_IRQ_STATE_BIT 4
`define SMFR_CLK_NS 20
`define SMFR_DG_RAIL_NS 21000
`define SMFR_DG_INTERNAL_REGULATOR_RAIL_UV_NS 24000
`define SMFR_DG_FAST_NS 10000
`define SMFR_DG_VBAT_NS 90000
`define SMFR_BOOST_WAIT_CYC 500
`define SMFR_SEC_WAIT_CYC 500
`define SMFR_TMR_W 16
`endif

// File: shared/smfr_pkg.sv
// types of the supply monitor fault reaction
package smfr_pkg;
  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_SAFE,
    ST_RESET,
    ST_OFF
  } smfr_state_type;

  // msb first: prim_extreme_overvoltage is bit 12, boost_uv is bit 0
  typedef struct packed {
    logic prim_extreme_overvoltage;
    logic vbat_uv;
    logic io_ov;
    logic internal_regulator_rail_ov;
    logic internal_regulator_rail_uv;
    logic [1:0] ext_ov;
    logic [1:0] ext_uv;
    logic sec_hov;
    logic boost_hov;
    logic boost_ov;
    logic boost_uv;
  } smfr_fault_type;

  typedef struct packed {
    logic supply_low_notify_sel;
    logic ext_overvolt_notify_sel;
    logic ext_overvolt_reset_sel;
    logic ext_undervolt_notify_sel;
    logic ext_undervolt_reset_sel;
    logic boost_overvolt_reset_sel;
    logic boost_undervolt_reset_sel;
  } smfr_cfg_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } smfr_bus_type;
endpackage : smfr_pkg

// File: hw/smfr_deglitch.sv
// deglitch filter for one monitor comparator
`timescale 1ns/1ps
module smfr_deglitch #(
  parameter int unsigned CYC = 1
) (
  input logic sys_clk,
  input logic reset,
  input logic raw_in,
  output logic filt_out
);
  localparam int unsigned W = $clog2(CYC + 1);
  logic [W-1:0] cnt_ff;
  logic filt_ff;

  // count consecutive cycles of the raw flag
  always_ff @(posedge sys_clk) begin
    if (reset || !raw_in) begin
      cnt_ff <= '0;
    end else if (cnt_ff != W'(CYC)) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // high after CYC cycles, drops at once
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      filt_ff <= 1'b0;
    end else begin
      filt_ff <= raw_in && (cnt_ff >= W'(CYC - 1));
    end
  end

  assign filt_out = filt_ff;
endmodule : smfr_deglitch

// File: hw/smfr_top.sv
// supply monitor fault reaction: filters, status, state and pins
// Notes on behaviour
// RL1 - boost undervoltage: status bit 3, optional RESET
// RL2 - boost undervoltage unselected: status only
// RL3 - boost overvoltage: status bit 3, RESET if selected
// RL4 - boost overvoltage unselected: SAFE, reset high
// RL5 - boost hard overvoltage: SAFE, disable, later OFF
// RL6 - secondary hard overvoltage persisting: OFF after wait
// RL7 - external undervoltage: RESET if selected, else SAFE if notified
// RL8 - external overvoltage: RESET if selected, else SAFE if notified
// RL9 - regulator rail fault: status bit 4, OFF
// RL10 - io overvoltage: status bit 7, no state change
// RL11 - io supply lost: pins pull low only
// RL12 - battery low: drive enable low only if selected
// RL13 - primary extreme overvoltage always forces OFF
// RL14 - status sticky, read clears once fault gone
// RL15 - short glitches ignored, status zero during ramp
// RL16 - worst reaction wins: OFF, RESET, SAFE
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "smfr_defines.svh"
module smfr_top #(
  parameter int unsigned VBAT_DG_CYC =
    (`SMFR_DG_VBAT_NS + `SMFR_CLK_NS - 1) / `SMFR_CLK_NS,
  parameter int unsigned BOOST_WAIT_CYC = `SMFR_BOOST_WAIT_CYC,
  parameter int unsigned SEC_WAIT_CYC = `SMFR_SEC_WAIT_CYC
) (
  input logic sys_clk,
  input logic reset,
  input smfr_pkg::smfr_fault_type fault_raw,
  input logic rails_ramping,
  input smfr_pkg::smfr_bus_type bus,
  output logic [7:0] rdata,
  output logic irq,
  output logic mcu_reset_out,
  output logic mcu_reset_out_oe,
  output logic drive_enable_irq_out,
  output logic drive_enable_irq_out_oe,
  output logic boost_disable,
  output logic sec_disable,
  output smfr_pkg::smfr_state_type dev_state
);
  import smfr_pkg::*;

  localparam int unsigned RAIL_CYC =
    (`SMFR_DG_RAIL_NS + `SMFR_CLK_NS - 1) / `SMFR_CLK_NS;
  localparam int unsigned INTERNAL_REGULATOR_RAIL_UV_CYC =
    (`SMFR_DG_INTERNAL_REGULATOR_RAIL_UV_NS + `SMFR_CLK_NS - 1) / `SMFR_CLK_NS;
  localparam int unsigned FAST_CYC =
    (`SMFR_DG_FAST_NS + `SMFR_CLK_NS - 1) / `SMFR_CLK_NS;
  localparam int BW = `SMFR_TMR_W;

  function automatic int unsigned dg_cyc(int i);
    case (i)
      8: dg_cyc = INTERNAL_REGULATOR_RAIL_UV_CYC;
      9, 10: dg_cyc = FAST_CYC;
      11: dg_cyc = VBAT_DG_CYC;
      default: dg_cyc = RAIL_CYC;
    endcase
  endfunction : dg_cyc

  logic [`SMFR_NFAULT-1:0] raw_vec;
  logic [`SMFR_NFAULT-1:0] filt_vec;
  logic [`SMFR_NFAULT-1:0] prev_ff;
  logic [`SMFR_NFAULT-1:0] ev_vec;
  smfr_fault_type flt;
  smfr_fault_type evf;
  smfr_cfg_type cfg_ff;
  smfr_state_type state_ff;
  smfr_state_type nxt_state;
  logic [BW-1:0] boost_tmr_ff;
  logic [BW-1:0] sec_tmr_ff;
  logic boost_dis_ff;
  logic sec_dis_ff;
  logic boost_to;
  logic sec_to;
  logic off_req;
  logic rst_req;
  logic safe_req;
  logic recover;
  logic any_fault;
  logic [7:0] uv_ff;
  logic [7:0] ov_ff;
  logic [7:0] prot_ff;
  logic [7:0] ext_ff;
  logic [7:0] uv_set, uv_lvl;
  logic [7:0] ov_set, ov_lvl;
  logic [7:0] prot_set, prot_lvl;
  logic [7:0] ext_set, ext_lvl;
  logic [7:0] irq_stat_ff;
  logic [7:0] irq_en_ff;
  logic [7:0] irq_set;
  logic [7:0] irq_clr;
  logic [7:0] rdata_ff;
  logic rst_lvl_ff, rst_oe_ff;
  logic den_lvl_ff, den_oe_ff;
  logic nxt_rst_lvl, nxt_den_lvl;

  assign raw_vec = fault_raw;

  // one filter per monitored comparator
  for (genvar i = 0; i < `SMFR_NFAULT; i++) begin : g_dg
    smfr_deglitch #(.CYC(dg_cyc(i))) u_dg (
      .sys_clk(sys_clk),
      .reset(reset),
      .raw_in(raw_vec[i]),
      .filt_out(filt_vec[i])
    );
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prev_ff <= '0;
    end else begin
      prev_ff <= filt_vec;
    end
  end

  assign ev_vec = filt_vec & ~prev_ff; // RL15
  assign flt = smfr_fault_type'(filt_vec);
  assign evf = smfr_fault_type'(ev_vec);
  assign any_fault = |filt_vec;
  assign recover = bus.wr && bus.addr == `SMFR_A_CTRL &&
    bus.wdata[`SMFR_CTRL_RECOVER_BIT];

  // shutdown timers after regulator disable
  assign boost_to = boost_dis_ff && flt.boost_hov &&
    boost_tmr_ff == BW'(BOOST_WAIT_CYC - 1); // RL5
  assign sec_to = sec_dis_ff && flt.sec_hov &&
    sec_tmr_ff == BW'(SEC_WAIT_CYC - 1); // RL6

  always_ff @(posedge sys_clk) begin
    if (reset || !(boost_dis_ff && flt.boost_hov)) begin
      boost_tmr_ff <= '0;
    end else if (!boost_to) begin
      boost_tmr_ff <= boost_tmr_ff + 1'b1; // RL5
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || !(sec_dis_ff && flt.sec_hov)) begin
      sec_tmr_ff <= '0;
    end else if (!sec_to) begin
      sec_tmr_ff <= sec_tmr_ff + 1'b1; // RL6
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      boost_dis_ff <= 1'b0;
      sec_dis_ff <= 1'b0;
    end else begin
      if (evf.boost_hov) begin
        boost_dis_ff <= 1'b1; // RL5
      end else if (recover && !flt.boost_hov) begin
        boost_dis_ff <= 1'b0;
      end
      if (evf.sec_hov) begin
        sec_dis_ff <= 1'b1; // RL6
      end else if (recover && !flt.sec_hov) begin
        sec_dis_ff <= 1'b0;
      end
    end
  end

  // reaction requests by severity
  always_comb begin
    off_req = evf.internal_regulator_rail_uv || evf.internal_regulator_rail_ov || // RL9
      evf.prim_extreme_overvoltage || boost_to || sec_to; // RL13
    rst_req = (evf.boost_uv && cfg_ff.boost_undervolt_reset_sel) || // RL1
      (evf.boost_ov && cfg_ff.boost_overvolt_reset_sel) || // RL3
      (|evf.ext_uv && cfg_ff.ext_undervolt_reset_sel) || // RL7
      (|evf.ext_ov && cfg_ff.ext_overvolt_reset_sel); // RL8
    safe_req = evf.boost_hov || // RL5
      (evf.boost_ov && !cfg_ff.boost_overvolt_reset_sel) || // RL4
      (|evf.ext_uv && cfg_ff.ext_undervolt_notify_sel) || // RL7
      (|evf.ext_ov && cfg_ff.ext_overvolt_notify_sel); // RL8
  end

  always_comb begin
    nxt_state = state_ff;
    if (state_ff != ST_OFF) begin
      if (off_req) begin
        nxt_state = ST_OFF; // RL16
      end else if (rst_req) begin
        nxt_state = ST_RESET; // RL16
      end else if (safe_req) begin
        if (state_ff != ST_RESET) begin
          nxt_state = ST_SAFE; // RL16
        end
      end else if (recover && !any_fault) begin
        nxt_state = ST_ACTIVE;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= ST_ACTIVE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // pin levels follow the next state
  always_comb begin
    nxt_rst_lvl = !(nxt_state == ST_RESET || nxt_state == ST_OFF);
    nxt_den_lvl = nxt_state == ST_ACTIVE &&
      !(flt.vbat_uv && cfg_ff.supply_low_notify_sel); // RL12
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rst_lvl_ff <= 1'b0;
      rst_oe_ff <= 1'b1;
      den_lvl_ff <= 1'b0;
      den_oe_ff <= 1'b1;
    end else begin
      rst_lvl_ff <= nxt_rst_lvl;
      den_lvl_ff <= nxt_den_lvl;
      rst_oe_ff <= !flt.io_ov || !nxt_rst_lvl; // RL11
      den_oe_ff <= !flt.io_ov || !nxt_den_lvl; // RL11
    end
  end

  // status set and level vectors
  always_comb begin
    uv_set = '0;
    uv_lvl = '0;
    ov_set = '0;
    ov_lvl = '0;
    prot_set = '0;
    prot_lvl = '0;
    ext_set = '0;
    ext_lvl = '0;
    uv_set[`SMFR_UV_BOOST_BIT] = evf.boost_uv; // RL1
    uv_lvl[`SMFR_UV_BOOST_BIT] = flt.boost_uv;
    uv_set[`SMFR_UV_INTERNAL_REGULATOR_RAIL_BIT] = evf.internal_regulator_rail_uv; // RL9
    uv_lvl[`SMFR_UV_INTERNAL_REGULATOR_RAIL_BIT] = flt.internal_regulator_rail_uv;
    uv_set[`SMFR_UV_VBAT_BIT] = evf.vbat_uv;
    uv_lvl[`SMFR_UV_VBAT_BIT] = flt.vbat_uv;
    ov_set[`SMFR_OV_BOOST_BIT] = evf.boost_ov; // RL3
    ov_lvl[`SMFR_OV_BOOST_BIT] = flt.boost_ov;
    ov_set[`SMFR_OV_INTERNAL_REGULATOR_RAIL_BIT] = evf.internal_regulator_rail_ov; // RL9
    ov_lvl[`SMFR_OV_INTERNAL_REGULATOR_RAIL_BIT] = flt.internal_regulator_rail_ov;
    ov_set[`SMFR_OV_IO_BIT] = evf.io_ov; // RL10
    ov_lvl[`SMFR_OV_IO_BIT] = flt.io_ov;
    prot_set[`SMFR_PROT_HOV_BIT] = evf.boost_hov; // RL5
    prot_lvl[`SMFR_PROT_HOV_BIT] = flt.boost_hov;
    ext_set[`SMFR_EXT_UV_LSB +: 2] = evf.ext_uv; // RL7
    ext_lvl[`SMFR_EXT_UV_LSB +: 2] = flt.ext_uv;
    ext_set[`SMFR_EXT_OV_LSB +: 2] = evf.ext_ov; // RL8
    ext_lvl[`SMFR_EXT_OV_LSB +: 2] = flt.ext_ov;
  end

  // sticky status, read clears bits whose fault is gone, set wins
  function automatic logic [7:0] stat_upd(logic [7:0] old,
    logic [7:0] set, logic [7:0] lvl, logic rd);
    stat_upd = (old & ~(rd ? ~lvl : 8'h00)) | set;
  endfunction : stat_upd

  always_ff @(posedge sys_clk) begin
    if (reset || rails_ramping) begin
      uv_ff <= 8'h00; // RL15
      ov_ff <= 8'h00;
      prot_ff <= 8'h00;
      ext_ff <= 8'h00;
    end else begin
      uv_ff <= stat_upd(uv_ff, uv_set, uv_lvl,
        bus.rd && bus.addr == `SMFR_A_UV_STAT); // RL14
      ov_ff <= stat_upd(ov_ff, ov_set, ov_lvl,
        bus.rd && bus.addr == `SMFR_A_OV_STAT); // RL14
      prot_ff <= stat_upd(prot_ff, prot_set, prot_lvl,
        bus.rd && bus.addr == `SMFR_A_PROT_STAT); // RL14
      ext_ff <= stat_upd(ext_ff, ext_set, ext_lvl,
        bus.rd && bus.addr == `SMFR_A_EXT_STAT); // RL14
    end
  end

  // configuration and interrupt enable
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg_ff <= '0;
      irq_en_ff <= 8'h00;
    end else if (bus.wr && bus.addr == `SMFR_A_CFG) begin
      cfg_ff <= smfr_cfg_type'(bus.wdata[6:0]);
    end else if (bus.wr && bus.addr == `SMFR_A_IRQ_EN) begin
      irq_en_ff <= bus.wdata;
    end
  end

  // interrupt status, set wins over clear
  always_comb begin
    irq_set = '0;
    irq_set[`SMFR_IRQ_UV_BIT] = |uv_set;
    irq_set[`SMFR_IRQ_OV_BIT] = |ov_set;
    irq_set[`SMFR_IRQ_PROT_BIT] = |prot_set;
    irq_set[`SMFR_IRQ_EXT_BIT] = |ext_set;
    irq_set[`SMFR_IRQ_STATE_BIT] = nxt_state != state_ff;
    irq_clr = (bus.wr && bus.addr == `SMFR_A_IRQ_CLR) ? bus.wdata : 8'h00;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_stat_ff <= 8'h00;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (reset || !bus.rd) begin
      rdata_ff <= 8'h00;
    end else begin
      case (bus.addr)
        `SMFR_A_UV_STAT: rdata_ff <= uv_ff;
        `SMFR_A_OV_STAT: rdata_ff <= ov_ff;
        `SMFR_A_PROT_STAT: rdata_ff <= prot_ff;
        `SMFR_A_EXT_STAT: rdata_ff <= ext_ff;
        `SMFR_A_CFG: rdata_ff <= {1'b0, cfg_ff};
        `SMFR_A_STATE: rdata_ff <= {6'h00, state_ff};
        `SMFR_A_IRQ_STAT: rdata_ff <= irq_stat_ff;
        `SMFR_A_IRQ_EN: rdata_ff <= irq_en_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  assign rdata = rdata_ff;
  assign irq = |(irq_stat_ff & irq_en_ff);
  assign mcu_reset_out = rst_lvl_ff;
  assign mcu_reset_out_oe = rst_oe_ff;
  assign drive_enable_irq_out = den_lvl_ff;
  assign drive_enable_irq_out_oe = den_oe_ff;
  assign boost_disable = boost_dis_ff;
  assign sec_disable = sec_dis_ff;
  assign dev_state = state_ff;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  logic quiet;
  assign quiet = !off_req && !recover && state_ff == ST_ACTIVE;

  sequence s_hov_hold;
    boost_dis_ff && flt.boost_hov &&
      boost_tmr_ff == BW'(BOOST_WAIT_CYC - 1);
  endsequence

  a_boost_uv_reset: assert property ( // RL1
    evf.boost_uv && cfg_ff.boost_undervolt_reset_sel && !off_req &&
    state_ff != ST_OFF
    |=> state_ff == ST_RESET && !mcu_reset_out && !drive_enable_irq_out)
    else $error("boost undervoltage did not reset");
  a_boost_uv_quiet: assert property ( // RL2
    evf.boost_uv && !cfg_ff.boost_undervolt_reset_sel && quiet &&
    !rst_req && !safe_req
    |=> state_ff == ST_ACTIVE && $stable(mcu_reset_out))
    else $error("boost undervoltage changed state");
  a_boost_ov_react: assert property ( // RL3
    evf.boost_ov && cfg_ff.boost_overvolt_reset_sel && !off_req &&
    state_ff != ST_OFF && !rails_ramping |=> ov_ff[`SMFR_OV_BOOST_BIT] &&
    state_ff == ST_RESET && !mcu_reset_out && !drive_enable_irq_out)
    else $error("boost overvoltage without reaction");
  a_boost_ov_safe: assert property ( // RL4
    evf.boost_ov && !cfg_ff.boost_overvolt_reset_sel && quiet &&
    !rst_req |=> state_ff == ST_SAFE && mcu_reset_out &&
    !drive_enable_irq_out)
    else $error("boost overvoltage did not enter safe");
  a_hov_timeout: assert property ( // RL5
    s_hov_hold |=> state_ff == ST_OFF ##1 state_ff == ST_OFF)
    else $error("boost hard overvoltage did not reach off");
  a_hov_safe: assert property ( // RL5
    evf.boost_hov && !off_req && !rst_req && state_ff != ST_OFF &&
    !rails_ramping |=> boost_disable && prot_ff[`SMFR_PROT_HOV_BIT] &&
    state_ff inside {ST_SAFE, ST_RESET})
    else $error("boost hard overvoltage reaction missing");
  a_sec_timeout: assert property ( // RL6
    sec_to |=> state_ff == ST_OFF)
    else $error("secondary hard overvoltage did not reach off");
  a_ext_uv_rst: assert property ( // RL7
    |evf.ext_uv && cfg_ff.ext_undervolt_reset_sel && !off_req &&
    state_ff != ST_OFF |=> state_ff == ST_RESET && !mcu_reset_out)
    else $error("external undervoltage did not reset");
  a_ext_ov_safe: assert property ( // RL8
    |evf.ext_ov && !cfg_ff.ext_overvolt_reset_sel &&
    cfg_ff.ext_overvolt_notify_sel && quiet && !rst_req && !rails_ramping
    |=> state_ff == ST_SAFE && ext_ff[`SMFR_EXT_OV_LSB +: 2] != 2'h0)
    else $error("external overvoltage did not enter safe");
  a_internal_regulator_rail_off: assert property ( // RL9
    (evf.internal_regulator_rail_uv || evf.internal_regulator_rail_ov) |=> state_ff == ST_OFF &&
    !mcu_reset_out && !drive_enable_irq_out)
    else $error("regulator rail fault did not reach off");
  a_io_no_state: assert property ( // RL10
    evf.io_ov && quiet && !rst_req && !safe_req && !rails_ramping
    |=> state_ff == ST_ACTIVE && ov_ff[`SMFR_OV_IO_BIT])
    else $error("io overvoltage changed state");
  a_io_pull_low: assert property ( // RL11
    $past(flt.io_ov) && (mcu_reset_out_oe || drive_enable_irq_out_oe)
    |-> !(mcu_reset_out_oe && mcu_reset_out) &&
    !(drive_enable_irq_out_oe && drive_enable_irq_out))
    else $error("pin driven high without io supply");
  a_vbat_notify: assert property ( // RL12
    flt.vbat_uv && cfg_ff.supply_low_notify_sel
    |=> !drive_enable_irq_out)
    else $error("battery low not signalled");
  a_extreme_overvoltage_off: assert property ( // RL13
    evf.prim_extreme_overvoltage |=> state_ff == ST_OFF)
    else $error("extreme overvoltage did not reach off");
  a_status_sticky: assert property ( // RL14
    uv_ff[`SMFR_UV_BOOST_BIT] && !rails_ramping &&
    !(bus.rd && bus.addr == `SMFR_A_UV_STAT && !flt.boost_uv)
    |=> uv_ff[`SMFR_UV_BOOST_BIT])
    else $error("status bit lost");
  a_status_ramp: assert property ( // RL15
    rails_ramping |=> uv_ff == 8'h00 && ov_ff == 8'h00)
    else $error("status set during ramp");
  a_worst_wins: assert property ( // RL16
    off_req && rst_req && state_ff != ST_OFF |=> state_ff == ST_OFF)
    else $error("milder reaction won");
endmodule : smfr_top

// File: verification/smfr_mcu_model.sv
// controller side of the reset and drive enable pins, with pull-ups
`timescale 1ns/1ps
module smfr_mcu_model (
  input wire logic rst_pin,
  input wire logic rst_oe,
  input wire logic de_pin,
  input wire logic de_oe,
  output logic rst_wire,
  output logic de_wire
);
  // released lines float up to the pull-up level
  assign rst_wire = rst_oe ? rst_pin : 1'b1;
  assign de_wire = de_oe ? de_pin : 1'b1;
endmodule : smfr_mcu_model

// File: verification/smfr_top_tb.sv
// self-checking bench of the supply monitor fault reaction
`timescale 1ns/1ps
`include "smfr_defines.svh"
module smfr_top_tb;
  import smfr_pkg::*;
  localparam int L = 1210;
  localparam int LIMIT = 60000;
  logic sys_clk;
  logic reset;
  smfr_fault_type fault_raw;
  logic rails_ramping;
  smfr_bus_type bus;
  logic [7:0] rdata;
  logic irq;
  logic mcu_reset_out;
  logic mcu_reset_out_oe;
  logic drive_enable_irq_out;
  logic drive_enable_irq_out_oe;
  logic boost_disable;
  logic sec_disable;
  smfr_state_type dev_state;
  logic rst_wire;
  logic de_wire;
  int err_total;
  int n_checks;
  int cyc;

  smfr_top #(
    .VBAT_DG_CYC(8),
    .BOOST_WAIT_CYC(4),
    .SEC_WAIT_CYC(4)
  ) u_smfr_top (
    .sys_clk(sys_clk),
    .reset(reset),
    .fault_raw(fault_raw),
    .rails_ramping(rails_ramping),
    .bus(bus),
    .rdata(rdata),
    .irq(irq),
    .mcu_reset_out(mcu_reset_out),
    .mcu_reset_out_oe(mcu_reset_out_oe),
    .drive_enable_irq_out(drive_enable_irq_out),
    .drive_enable_irq_out_oe(drive_enable_irq_out_oe),
    .boost_disable(boost_disable),
    .sec_disable(sec_disable),
    .dev_state(dev_state)
  );

  smfr_mcu_model u_smfr_mcu_model (
    .rst_pin(mcu_reset_out),
    .rst_oe(mcu_reset_out_oe),
    .de_pin(drive_enable_irq_out),
    .de_oe(drive_enable_irq_out_oe),
    .rst_wire(rst_wire),
    .de_wire(de_wire)
  );

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic test_done();
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      test_done();
    end
  end

  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(logic [3:0] a, logic [7:0] exp);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    chk("rdata", rdata, exp);
  endtask : rd

  task automatic wait_cyc(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_cyc

  // outputs seen as {state, reset wire, oe, drive wire, oe, disables}
  task automatic chk_outs(logic [7:0] exp);
    chk("outs", {dev_state, rst_wire, mcu_reset_out_oe, de_wire,
      drive_enable_irq_out_oe, boost_disable, sec_disable}, exp);
  endtask : chk_outs

  task automatic do_reset();
    @(posedge sys_clk);
    reset <= 1'b1;
    wait_cyc(2);
    @(posedge sys_clk);
    reset <= 1'b0;
  endtask : do_reset

  // one fault pattern: hold, check pins, release, read status twice
  task automatic run(logic [12:0] mask, logic [7:0] cfg, int hold,
                     logic ramp, logic [7:0] outs, logic [3:0] a,
                     logic [7:0] s1, logic [7:0] s2);
    do_reset();
    wr(`SMFR_A_CFG, cfg);
    @(posedge sys_clk);
    rails_ramping <= ramp;
    fault_raw <= mask;
    wait_cyc(hold);
    chk_outs(outs);
    @(posedge sys_clk);
    fault_raw <= '0;
    rails_ramping <= 1'b0;
    wait_cyc(4);
    rd(a, s1);
    rd(a, s2);
  endtask : run

  initial begin
    reset = 1'b1;
    fault_raw = '0;
    rails_ramping = 1'b0;
    bus = '0;
    err_total = 0;
    n_checks = 0;
    cyc = 0;
    wait_cyc(6);
    reset <= 1'b0;
    wait_cyc(2);
    chk_outs(8'h3c);
    run(13'h0001, 8'h01, L, 0, 8'h94, `SMFR_A_UV_STAT, 8'h08, 8'h00);
    run(13'h0001, 8'h00, L, 0, 8'h3c, `SMFR_A_UV_STAT, 8'h08, 8'h00);
    run(13'h0002, 8'h02, L, 0, 8'h94, `SMFR_A_OV_STAT, 8'h08, 8'h00);
    run(13'h0002, 8'h00, L, 0, 8'h74, `SMFR_A_OV_STAT, 8'h08, 8'h00);
    run(13'h0004, 8'h00, L, 0, 8'hd6, `SMFR_A_PROT_STAT, 8'h08, 8'h00);
    run(13'h0008, 8'h00, L, 0, 8'hd5, `SMFR_A_STATE, 8'h03, 8'h03);
    run(13'h0010, 8'h04, L, 0, 8'h94, `SMFR_A_EXT_STAT, 8'h01, 8'h00);
    run(13'h0020, 8'h08, L, 0, 8'h74, `SMFR_A_EXT_STAT, 8'h02, 8'h00);
    run(13'h0040, 8'h10, L, 0, 8'h94, `SMFR_A_EXT_STAT, 8'h10, 8'h00);
    run(13'h0080, 8'h20, L, 0, 8'h74, `SMFR_A_EXT_STAT, 8'h20, 8'h00);
    run(13'h0100, 8'h00, L, 0, 8'hd4, `SMFR_A_UV_STAT, 8'h10, 8'h00);
    run(13'h0200, 8'h00, L, 0, 8'hd4, `SMFR_A_OV_STAT, 8'h10, 8'h00);
    run(13'h0400, 8'h00, L, 0, 8'h28, `SMFR_A_OV_STAT, 8'h80, 8'h00);
    run(13'h0401, 8'h01, L, 0, 8'h94, `SMFR_A_OV_STAT, 8'h80, 8'h00);
    run(13'h0800, 8'h00, L, 0, 8'h3c, `SMFR_A_UV_STAT, 8'h40, 8'h00);
    run(13'h0800, 8'h40, L, 0, 8'h34, `SMFR_A_UV_STAT, 8'h40, 8'h00);
    run(13'h1000, 8'h7f, L, 0, 8'hd4, `SMFR_A_STATE, 8'h03, 8'h03);
    run(13'h0003, 8'h01, L, 0, 8'h94, `SMFR_A_OV_STAT, 8'h08, 8'h00);
    run(13'h0101, 8'h01, L, 0, 8'hd4, `SMFR_A_UV_STAT, 8'h18, 8'h00);
    run(13'h1001, 8'h01, L, 0, 8'hd4, `SMFR_A_UV_STAT, 8'h08, 8'h00);
    run(13'h0001, 8'h01, 1000, 0, 8'h3c, `SMFR_A_UV_STAT, 8'h00, 8'h00);
    run(13'h0001, 8'h00, L, 1, 8'h3c, `SMFR_A_UV_STAT, 8'h00, 8'h00);
    // interrupt masking, clearing and register access
    do_reset();
    wr(`SMFR_A_CFG, 8'h00);
    wr(`SMFR_A_IRQ_EN, 8'h00);
    @(posedge sys_clk);
    fault_raw <= 13'h0001;
    wait_cyc(L);
    chk("irq", {7'h00, irq}, 8'h00);
    rd(`SMFR_A_UV_STAT, 8'h08);
    rd(`SMFR_A_UV_STAT, 8'h08);
    rd(`SMFR_A_IRQ_STAT, 8'h01);
    wr(`SMFR_A_IRQ_EN, 8'h01);
    wait_cyc(2);
    chk("irq", {7'h00, irq}, 8'h01);
    wr(`SMFR_A_IRQ_CLR, 8'h01);
    wait_cyc(2);
    chk("irq", {7'h00, irq}, 8'h00);
    rd(`SMFR_A_IRQ_STAT, 8'h00);
    wr(`SMFR_A_CFG, 8'h55);
    rd(`SMFR_A_CFG, 8'h55);
    wr(`SMFR_A_UV_STAT, 8'hff);
    rd(4'hf, 8'h00);
    @(posedge sys_clk);
    fault_raw <= '0;
    wait_cyc(4);
    rd(`SMFR_A_UV_STAT, 8'h08);
    rd(`SMFR_A_UV_STAT, 8'h00);
    // safe state left by a recover write once the fault is gone
    wr(`SMFR_A_CFG, 8'h00);
    @(posedge sys_clk);
    fault_raw <= 13'h0002;
    wait_cyc(L);
    chk_outs(8'h74);
    wr(`SMFR_A_CTRL, 8'h01);
    wait_cyc(2);
    chk_outs(8'h74);
    rd(`SMFR_A_IRQ_STAT, 8'h12);
    @(posedge sys_clk);
    fault_raw <= '0;
    wait_cyc(4);
    wr(`SMFR_A_CTRL, 8'h01);
    wait_cyc(3);
    chk_outs(8'h3c);
    test_done();
  end
endmodule : smfr_top_tb
